/* inc/trace_trig_params.svh */
// Register offsets, field positions and reset values of the trigger control block
`ifndef TRACE_TRIG_PARAMS_SVH
`define TRACE_TRIG_PARAMS_SVH
`define OFS_PORT_OVERRIDE 12'h000
`define OFS_MASTER_OVERRIDE 12'h004
`define OFS_TRIG_CSR 12'h008
`define OFS_TRIG_ENABLE 12'h00C
`define OFS_FEATURE_ONE 12'h010
`define OFS_TRACE_CSR 12'h014
`define OFS_IRQ_STATUS 12'h018
`define OFS_IRQ_MASK 12'h01C
`define BIT_SHOT_MODE 0
`define BIT_TRIG_FLAG 1
`define BIT_TRIG_CLEAR 2
`define BIT_TRIG_EN_PORT 3
`define BIT_TRIG_EN_DIRECT 4
`define BIT_MSEL_EN 0
`define MSEL_LSB 15
`define PSEL_LSB 2
`define FEAT_TRIGCSR_BIT 0
`define TRIGGER_TRACE_ID 7'h7D
`define RST_TRIG_CSR 5'h00
`define RST_TRACE_ID 7'h00
`define RST_PORT_OVERRIDE 32'h00000000
`define RST_MASTER_OVERRIDE 32'h00000000
`define RST_IRQ 2'h0
`endif

/* inc/trace_trig_pkg.sv */
// Types of the trigger control block
package trace_trig_pkg;
   typedef enum logic [1:0] {ovr_none, ovr_guaranteed, ovr_invariant, ovr_reserved} override_t;
   typedef enum {trig_idle, trig_fired} trig_state_t;
endpackage

/* sim/stim_src.sv */
// Model of the bus masters writing stimulus ports
`timescale 1ns/1ps
`default_nettype none
module stim_src (
   // Clock
   input wire logic pclk,
   // Stimulus writes
   output logic sp_valid,
   output logic [15:0] sp_port,
   output logic [15:0] sp_master,
   output logic sp_trig_loc,
   output logic [31:0] sp_data
);
   // ****
   // One write, then inverted leftovers
   // ****
   initial {sp_valid, sp_port, sp_master, sp_trig_loc, sp_data} = '0;
   task automatic send(input logic [15:0] p, m, input logic t, input logic [31:0] d);
      {sp_valid, sp_port, sp_master, sp_trig_loc, sp_data} <= {1'h1, p, m, t, d};
      @(posedge pclk);
      {sp_valid, sp_port, sp_master, sp_trig_loc, sp_data} <= {1'h0, ~{p, m, t, d}};
      @(posedge pclk);
   endtask
endmodule
`default_nettype wire

/* sim/trace_trig_ctrl_assertions.sv */
// Port checks of the trace trigger control block
`timescale 1ns/1ps
`default_nettype none
module trace_trig_ctrl_assertions (
   // APB side
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   // Stimulus and trace
   input wire logic sp_valid,
   input wire logic [31:0] sp_data,
   input wire logic tr_valid,
   input wire logic [31:0] tr_data,
   input wire logic tr_guaranteed,
   input wire logic tr_invariant
);
   // ****
   // Checks
   // ****
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_ans; psel && !penable |=> pready; endproperty
   a_ans: assert property (p_ans) else $error("no answer");
   property p_one; pready |=> !pready; endproperty
   a_one: assert property (p_one) else $error("ready held");
   property p_err; psel && !penable && paddr > 12'h01C |=> pslverr; endproperty
   a_err: assert property (p_err) else $error("no refusal");
   property p_ok; psel && !penable && paddr < 12'h020 && paddr[1:0] == 2'h0 |=> !pslverr;
   endproperty
   a_ok: assert property (p_ok) else $error("bad refusal");
   property p_fol; sp_valid |=> tr_valid; endproperty
   a_fol: assert property (p_fol) else $error("no trace");
   property p_quiet; !sp_valid |=> !tr_valid; endproperty
   a_quiet: assert property (p_quiet) else $error("stray trace");
   property p_data; sp_valid |=> tr_data == $past(sp_data); endproperty
   a_data: assert property (p_data) else $error("bad data");
   property p_excl; tr_valid |-> !(tr_guaranteed && tr_invariant); endproperty
   a_excl: assert property (p_excl) else $error("two overrides");
endmodule
bind trace_trig_ctrl trace_trig_ctrl_assertions u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .sp_valid(sp_valid), .sp_data(sp_data), .tr_valid(tr_valid), .tr_data(tr_data),
   .tr_guaranteed(tr_guaranteed), .tr_invariant(tr_invariant));
`default_nettype wire

/* sim/trace_trig_ctrl_tb.sv */
// Bench of the trace trigger control block
`timescale 1ns/1ps
`default_nettype none
module trace_trig_ctrl_tb;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, q;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, tr_data, sp_data, seed = 32'h8F2087D7;
   logic pready, pslverr, sp_valid, sp_trig_loc, tr_valid, tr_guaranteed, tr_invariant, irq;
   logic [15:0] sp_port, sp_master;
   logic [6:0] tr_id;
   logic [40:0] tq[$];
   logic [64:0] rq[$], re;
   int n_fail = 0, n_tests = 0;
   trace_trig_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sp_valid(sp_valid), .sp_port(sp_port), .sp_master(sp_master),
      .sp_trig_loc(sp_trig_loc), .sp_data(sp_data), .tr_valid(tr_valid), .tr_id(tr_id),
      .tr_data(tr_data), .tr_guaranteed(tr_guaranteed), .tr_invariant(tr_invariant),
      .irq(irq));
   stim_src src (.pclk(pclk), .sp_valid(sp_valid), .sp_port(sp_port),
      .sp_master(sp_master), .sp_trig_loc(sp_trig_loc), .sp_data(sp_data));
   initial forever #20 pclk = ~pclk;
   // ****
   // Helpers
   // ****
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input string s, input logic [63:0] e, g);
      n_tests++;
      n_fail += (g !== e);
      if (g !== e) $display("FAIL %s expected %h seen %h", s, e, g);
   endtask
   task automatic tally_and_finish();
      if (n_fail == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic apb(input logic [11:0] a, input logic wr, input logic [31:0] d, m, e);
      {psel, paddr, pwrite, pwdata} <= {1'h1, a, wr, d};
      @(posedge pclk);
      penable <= 1'h1;
      if (!wr) rq.push_back({m, a > 12'h01C, e});
      do @(posedge pclk); while (pready !== 1'h1);
      {psel, penable} <= 2'h0;
      @(posedge pclk);
   endtask
   task automatic w(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'h1, d, 32'h0, 32'h0);
   endtask
   task automatic r(input logic [11:0] a, input logic [31:0] m, e);
      apb(a, 1'h0, 32'h0, m, e);
   endtask
   task automatic s(input logic [15:0] p, m, input logic t,
      input logic [6:0] id, input logic [1:0] o);
      logic [31:0] d;
      d = xs();
      tq.push_back({id, o, d});
      src.send(p, m, t, d);
   endtask
   always @(posedge pclk)
   begin
      if (tr_valid === 1'h1)
         chk("trace", tq.size() ? tq.pop_front() : 'x, {tr_id, tr_guaranteed, tr_invariant, tr_data});
      if (psel && penable && pready === 1'h1 && !pwrite)
      begin
         re = rq.pop_front();
         chk("read", re[32:0], {pslverr, prdata & re[64:33]});
      end
   end
   // ****
   // Scenarios
   // ****
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      r(12'h008, 32'h0000001F, 32'h00000000);
      r(12'h010, 32'h00000001, 32'h00000001);
      r(12'h014, 32'h00000000, 32'h00000000);
      r(12'h040, 32'h00000000, 32'h00000000);
      w(12'h014, 32'h00150000);
      w(12'h000, 32'h0000000D);
      s(16'h0001, 16'(xs()), 1'h0, 7'h15, 2'h2);
      s(16'h0002, 16'h0001, 1'h0, 7'h15, 2'h0);
      w(12'h004, 32'h00018001);
      s(16'h0001, 16'h0001, 1'h0, 7'h15, 2'h2);
      s(16'h0001, 16'h0005, 1'h0, 7'h15, 2'h0);
      w(12'h000, 32'h0000000E);
      s(16'h0001, 16'h0001, 1'h0, 7'h15, 2'h1);
      w(12'h00C, 32'h00000002);
      w(12'h008, 32'h00000008);
      s(16'h0001, 16'h0003, 1'h0, 7'h7D, 2'h0);
      s(16'h0001, 16'h0003, 1'h0, 7'h7D, 2'h0);
      s(16'h0003, 16'h0003, 1'h1, 7'h15, 2'h0);
      r(12'h008, 32'h00000002, 32'h00000000);
      w(12'h008, 32'h00000010);
      s(16'h0003, 16'h0003, 1'h1, 7'h7D, 2'h0);
      s(16'h0001, 16'h0003, 1'h0, 7'h15, 2'h0);
      w(12'h008, 32'h00000019);
      w(12'h008, 32'h0000001D);
      r(12'h008, 32'h0000001F, 32'h00000019);
      s(16'h0001, 16'h0003, 1'h0, 7'h7D, 2'h0);
      s(16'h0001, 16'h0003, 1'h0, 7'h15, 2'h0);
      r(12'h008, 32'h0000001F, 32'h0000001B);
      w(12'h008, 32'h00000019);
      r(12'h008, 32'h00000002, 32'h00000002);
      w(12'h008, 32'h0000001D);
      r(12'h008, 32'h00000002, 32'h00000000);
      s(16'h0001, 16'h0003, 1'h0, 7'h7D, 2'h0);
      w(12'h01C, 32'h00000000);
      repeat (2) @(posedge pclk);
      q = irq;
      w(12'h01C, 32'h00000003);
      repeat (2) @(posedge pclk);
      chk("irq mask", 1'h1, q ^ irq);
      w(12'h018, 32'h00000003);
      r(12'h018, 32'h00000003, 32'h00000000);
      repeat (2) @(posedge pclk);
      chk("irq clear", 1'h0, irq);
      w(12'h008, 32'h00000019);
      presetn <= 1'h0;
      @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      chk("irq reset", 1'h0, irq);
      r(12'h008, 32'h0000001F, 32'h00000000);
      chk("queues", 1'h0, tq.size() + rq.size());
      tally_and_finish();
   end
   initial
   begin
      repeat (2000) @(posedge pclk);
      n_fail++;
      tally_and_finish();
   end
endmodule
`default_nettype wire

/* src/trace_trig_ctrl.sv */
// Stimulus port master override and trace trigger control over APB
// Notes on behaviour
// R1 - Selection off: override applies to every master
// R2 - Selection on: override only for selected masters
// R3 - Mode 01: guaranteed if port and master selected
// R4 - Mode 10: invariant timing if both selected
// R5 - Other writes keep normal behaviour
// R6 - Feature register reports trigger register present
// R7 - Direct trigger writes emit trigger trace ID
// R8 - Enabled port writes emit trigger trace ID
// R9 - Reset clears trigger enables and mode
// R10 - Single shot: writing one clears flag; the code drops the clear if trig_req is high in the cycle it acts
// R11 - Software avoids clear in multi-shot mode
// R12 - Single shot: flag shows trigger occurred
// R13 - Multi-shot: flag value undefined, reads zero
// R14 - Mode bit: zero multi, one single
// R15 - Trace control register always present
// R16 - Software encodes master selection as mask
// R17 - Master selection field at bits 31:15
// R18 - Single shot fires once until cleared
// R19 - Clear reads zero, acts next cycle
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "trace_trig_params.svh"
module trace_trig_ctrl
   import trace_trig_pkg::*;
#(
   parameter int NUM_PORTS = 32,
   parameter int PORT_W = 16,
   parameter int MASTER_W = 16
)(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Stimulus port write stream
   input wire logic sp_valid,
   input wire logic [PORT_W-1:0] sp_port,
   input wire logic [MASTER_W-1:0] sp_master,
   input wire logic sp_trig_loc,
   input wire logic [31:0] sp_data,
   // Trace bus output
   output logic tr_valid,
   output logic [6:0] tr_id,
   output logic [31:0] tr_data,
   output logic tr_guaranteed,
   output logic tr_invariant,
   // Interrupt
   output logic irq
);
   // ***************************************************
   // Register storage
   // ***************************************************
   logic [31:0] port_override_register_reg;
   logic [31:0] master_override_reg;
   logic [4:0] port_trigger_control_status_reg;
   logic [NUM_PORTS-1:0] port_trigger_enable_register_reg;
   logic [6:0] trace_id_reg;
   logic [1:0] irq_status_reg;
   logic [1:0] irq_mask_reg;
   logic clear_pending_reg;
   trig_state_t trig_state_reg;
   logic wr_en;
   logic rd_en;
   logic [31:0] rd_next;
   logic addr_ok;
   logic [16:0] master_select_field;
   logic master_select_enable;
   override_t override_control;
   logic [15:0] port_select_field;
   logic port_hit;
   logic master_hit;
   logic trig_req;
   logic trig_fire;
   logic [1:0] irq_event;
   logic wr_port_ovr;
   logic wr_master_ovr;
   logic wr_trig_csr;
   logic wr_trig_en;
   logic wr_trace_csr;
   logic wr_irq_status;
   logic wr_irq_mask;

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;

   // ***************************************************
   // Write strobes per register
   // ***************************************************
   assign wr_port_ovr = wr_en && paddr == `OFS_PORT_OVERRIDE;
   assign wr_master_ovr = wr_en && paddr == `OFS_MASTER_OVERRIDE;
   assign wr_trig_csr = wr_en && paddr == `OFS_TRIG_CSR;
   assign wr_trig_en = wr_en && paddr == `OFS_TRIG_ENABLE;
   assign wr_trace_csr = wr_en && paddr == `OFS_TRACE_CSR;
   assign wr_irq_status = wr_en && paddr == `OFS_IRQ_STATUS;
   assign wr_irq_mask = wr_en && paddr == `OFS_IRQ_MASK;

   assign master_select_field = master_override_reg[31:`MSEL_LSB]; // [R17]
   assign master_select_enable = master_override_reg[`BIT_MSEL_EN];
   assign override_control = override_t'(port_override_register_reg[1:0]);
   assign port_select_field = port_override_register_reg[`PSEL_LSB+15:`PSEL_LSB];

   // ***************************************************
   // Power-of-two selection match
   // ***************************************************
   function automatic logic sel_match(input logic [16:0] sel, input logic [15:0] id);
      logic [16:0] mask;
      logic [16:0] idx;
      logic found;
      mask = 17'h00000;
      found = 1'b0;
      idx = {id, 1'b1};
      for (int i = 0; i < 17; i++)
      begin
         if (!found)
         begin
            mask[i] = 1'b1;
            found = sel[i];
         end
      end
      sel_match = found && ((sel & ~mask) == (idx & ~mask));
   endfunction

   always_comb
   begin
      port_hit = sel_match({1'b0, port_select_field}, 16'(sp_port));
      master_hit = !master_select_enable
                   || sel_match(master_select_field, 16'(sp_master)); // [R1] [R2]
   end

   // ***************************************************
   // Register write
   // ***************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         port_override_register_reg <= `RST_PORT_OVERRIDE;
      else if (wr_port_ovr)
         port_override_register_reg <= pwdata;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         master_override_reg <= `RST_MASTER_OVERRIDE;
      else if (wr_master_ovr)
         master_override_reg <= {pwdata[31:`MSEL_LSB], 14'h0, pwdata[`BIT_MSEL_EN]}; // [R17]
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         port_trigger_enable_register_reg <= '0;
      else if (wr_trig_en)
         port_trigger_enable_register_reg <= pwdata[NUM_PORTS-1:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         trace_id_reg <= `RST_TRACE_ID;
      else if (wr_trace_csr)
         trace_id_reg <= pwdata[22:16];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_mask_reg <= `RST_IRQ;
      else if (wr_irq_mask)
         irq_mask_reg <= pwdata[1:0];
   end

   // ***************************************************
   // Trigger control and status
   // ***************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port_trigger_control_status_reg <= `RST_TRIG_CSR; // [R9]
         clear_pending_reg <= 1'b0;
      end
      else
      begin
         clear_pending_reg <= wr_trig_csr && pwdata[`BIT_TRIG_CLEAR]; // [R10] [R19]
         if (wr_trig_csr)
         begin
            port_trigger_control_status_reg[`BIT_TRIG_EN_DIRECT] <= pwdata[4];
            port_trigger_control_status_reg[`BIT_TRIG_EN_PORT] <= pwdata[3];
            port_trigger_control_status_reg[`BIT_SHOT_MODE] <= pwdata[0]; // [R14]
         end
      end
   end

   assign trig_req = sp_valid && ((sp_trig_loc
                     && port_trigger_control_status_reg[`BIT_TRIG_EN_DIRECT]) // [R7]
                     || (port_trigger_enable_register_reg[sp_port[$clog2(NUM_PORTS)-1:0]]
                     && port_trigger_control_status_reg[`BIT_TRIG_EN_PORT])); // [R8]
   assign trig_fire = trig_req && !(port_trigger_control_status_reg[`BIT_SHOT_MODE]
                      && trig_state_reg == trig_fired); // [R18]

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         trig_state_reg <= trig_idle;
      else
      begin
         case (trig_state_reg)
            trig_idle:
               if (trig_fire && port_trigger_control_status_reg[`BIT_SHOT_MODE])
                  trig_state_reg <= trig_fired; // [R12] [R18]
            trig_fired:
               if (clear_pending_reg && !trig_req)
                  trig_state_reg <= trig_idle; // [R10]
            default: trig_state_reg <= trig_idle;
         endcase
      end
   end

   // ***************************************************
   // Trace bus output
   // ***************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tr_valid <= 1'b0;
         tr_data <= 32'h00000000;
      end
      else
      begin
         tr_valid <= sp_valid;
         tr_data <= sp_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tr_id <= 7'h00;
      else
         tr_id <= trig_fire ? `TRIGGER_TRACE_ID : trace_id_reg; // [R7] [R8]
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tr_guaranteed <= 1'b0;
         tr_invariant <= 1'b0;
      end
      else
      begin
         tr_guaranteed <= sp_valid && port_hit && master_hit
                          && override_control == ovr_guaranteed; // [R3] [R5]
         tr_invariant <= sp_valid && port_hit && master_hit
                         && override_control == ovr_invariant; // [R4] [R5]
      end
   end

   // ***************************************************
   // Interrupts
   // ***************************************************
   assign irq_event = {trig_fire, sp_valid && sp_trig_loc};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_status_reg <= `RST_IRQ;
      else if (wr_irq_status)
         irq_status_reg <= (irq_status_reg & ~pwdata[1:0]) | irq_event;
      else
         irq_status_reg <= irq_status_reg | irq_event;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= |(irq_status_reg & irq_mask_reg);
   end

   // ***************************************************
   // Register read
   // ***************************************************
   always_comb
   begin
      rd_next = 32'h00000000;
      addr_ok = 1'b1;
      case (paddr)
         `OFS_PORT_OVERRIDE: rd_next = port_override_register_reg;
         `OFS_MASTER_OVERRIDE: rd_next = master_override_reg;
         `OFS_TRIG_CSR: rd_next = {27'h0000000,
            port_trigger_control_status_reg[4:3], 1'b0, // [R19]
            port_trigger_control_status_reg[0] && trig_state_reg == trig_fired, // [R12] [R13]
            port_trigger_control_status_reg[0]};
         `OFS_TRIG_ENABLE: rd_next = 32'(port_trigger_enable_register_reg);
         `OFS_FEATURE_ONE: rd_next = 32'h00000001; // [R6]
         `OFS_TRACE_CSR: rd_next = {9'h000, trace_id_reg, 16'h0000}; // [R15]
         `OFS_IRQ_STATUS: rd_next = {30'h00000000, irq_status_reg};
         `OFS_IRQ_MASK: rd_next = {30'h00000000, irq_mask_reg};
         default: addr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         if (psel && !penable && !pwrite)
            prdata <= rd_next;
      end
   end
endmodule
`default_nettype wire
